// ==== logic/rst_clk_consts.svh ====
`ifndef RST_CLK_CONSTS_SVH
`define RST_CLK_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_BROWNOUT_CTRL 12'h0030
`define OFS_RESET_CAUSE 12'h005C
`define OFS_RUN_CLOCK_CFG 12'h0060
`define OFS_REGULATOR_CTRL 12'h0034
`define OFS_SOFT_RESET0 12'h0040
`define OFS_SOFT_RESET1 12'h0044
`define OFS_SOFT_RESET2 12'h0048
`define OFS_CLOCK_GATE0 12'h0100
`define OFS_CLOCK_GATE1 12'h0104
`define OFS_CLOCK_GATE2 12'h0108
`define OFS_SYS_RESET_REQ 12'h000C
`define OFS_WDOG_LOAD 12'h0200
`define OFS_WDOG_CTRL 12'h0208
`define OFS_WDOG_INT_CLR 12'h020C
`define OFS_WDOG_STATUS 12'h0210
`define OFS_WDOG_VALUE 12'h0204

// ****************************************
// Field positions
// ****************************************
`define BIT_BOR_RESET_SEL 1
`define BIT_SYS_RESET_REQ 2
`define BIT_WDOG_INT_EN 0
`define BIT_WDOG_RESET_EN 1
`define BIT_CAUSE_EXT 0
`define BIT_CAUSE_POR 1
`define BIT_CAUSE_BOR 2
`define BIT_CAUSE_WDT 3
`define BIT_CAUSE_SW 4
`define POS_BYPASS 11
`define POS_OSC_SRC 4
`define POS_REGULATOR_VOLTAGE_ADJUST_W 6

// ****************************************
// Reset values and timing
// ****************************************
`define RST_RUN_CLOCK_CFG 32'h0000_0810
`define RST_WDOG_LOAD 32'hFFFF_FFFF
`define RST_HOLD_NS 64
`define RST_HOLD_CYC (((`RST_HOLD_NS) + 7) / 8)

`endif

// ==== logic/rst_clk_pkg.sv ====
package rst_clk_pkg;

    // Reset sequence phases
    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b000,
        SEQ_HOLD  = 3'b001,
        SEQ_SP    = 3'b010,
        SEQ_PC    = 3'b011,
        SEQ_INSTR = 3'b100,
        SEQ_RUN   = 3'b101
    } seq_state_e;

    // System clock selections
    typedef enum logic [2:0] {
        CLK_INTERNAL_OSC     = 3'b000,
        CLK_MAIN     = 3'b001,
        CLK_SLOW30K  = 3'b010,
        CLK_PLL      = 3'b011,
        CLK_INTERNAL_OSC_DV4 = 3'b100
    } clk_sel_e;

    // Core fetch strobes
    typedef struct packed {
        logic fetch_sp;
        logic fetch_pc;
        logic fetch_instr;
        logic running;
    } boot_fetch_s;

    // APB request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

endpackage

// ==== logic/rst_clk_ctrl.sv ====
`timescale 1ns/10ps
`include "rst_clk_consts.svh"
module rst_clk_ctrl
    import rst_clk_pkg::*;
#(
    parameter int NUM_PERIPH = 32,
    parameter int NUM_DOMAINS = 2,
    parameter int HOLD_CYC = `RST_HOLD_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Reset sources and deep sleep request
    input wire logic i_por,
    input wire logic i_ext_reset,
    input wire logic i_brownout,
    input wire logic i_deep_sleep,
    // Resets and interrupts out
    output logic o_core_reset,
    output logic [2:0][NUM_PERIPH-1:0][NUM_DOMAINS-1:0] o_periph_reset,
    output logic o_brownout_irq,
    output logic o_wdog_irq,
    // Core boot sequence
    output boot_fetch_s o_boot_fetch,
    // Power and clock
    output logic [`POS_REGULATOR_VOLTAGE_ADJUST_W-1:0] o_regulator_voltage_adjust,
    output logic o_main_osc_enable,
    output logic [2:0] o_sys_clk_sel,
    output logic o_pll_ref_main
);

    // ****************************************
    // Registers
    // ****************************************
    // Software-visible state; unused upper bits read as zero, except in run_clock_config_r, which keeps the whole word written
    // so software may write whole words without masking
    logic [1:0] brownout_ctrl_reg_r;
    logic [31:0] reset_cause_reg_r;
    logic [2:0][31:0] peripheral_soft_reset_regs_r;
    logic [2:0][31:0] clock_gate_r;
    logic [31:0] run_clock_config_r;
    logic [`POS_REGULATOR_VOLTAGE_ADJUST_W-1:0] regulator_ctrl_reg_r;
    logic [31:0] watchdog_reload_value_r;
    logic [31:0] wdog_count_r;
    logic [1:0] wdog_ctrl_r;
    logic wdog_int_r;
    logic wdog_reset_r;
    logic sys_req_r;
    logic [7:0] hold_cnt_r;
    seq_state_e seq_r;
    seq_state_e seq_nxt;
    // Bus decode and reset wires
    logic wr;
    logic rd;
    logic addr_ok;
    logic bor_reset;
    logic sys_reset;
    logic wdog_int_clr;
    logic [2:0] src;
    logic bypass;

    // ****************************************
    // APB decode
    // ****************************************
    // Zero wait state: every access completes in its access phase
    // Writes land on the access edge; read data was taken on the
    // setup edge, so it stands for the whole access phase
    assign o_pready = 1'b1;
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & ~i_pwrite;
    assign o_pslverr = i_psel & i_penable & ~addr_ok;
    assign wdog_int_clr = wr && i_paddr == `OFS_WDOG_INT_CLR;

    // Address check for unmapped error
    // Holes drop writes and read as zero, so a stray pointer
    // cannot disturb the reset or clock state
    always_comb begin
        case (i_paddr)
            `OFS_BROWNOUT_CTRL, `OFS_RESET_CAUSE, `OFS_RUN_CLOCK_CFG,
            `OFS_REGULATOR_CTRL, `OFS_SOFT_RESET0, `OFS_SOFT_RESET1,
            `OFS_SOFT_RESET2, `OFS_CLOCK_GATE0, `OFS_CLOCK_GATE1,
            `OFS_CLOCK_GATE2, `OFS_SYS_RESET_REQ, `OFS_WDOG_LOAD,
            `OFS_WDOG_CTRL, `OFS_WDOG_INT_CLR, `OFS_WDOG_STATUS,
            `OFS_WDOG_VALUE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data registered in the setup cycle, valid in access phase
    // Write-only offsets read as zero
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd & ~i_penable) begin
            case (i_paddr)
                `OFS_BROWNOUT_CTRL: o_prdata <= {30'h0, brownout_ctrl_reg_r};
                `OFS_RESET_CAUSE: o_prdata <= reset_cause_reg_r;
                `OFS_RUN_CLOCK_CFG: o_prdata <= run_clock_config_r;
                `OFS_REGULATOR_CTRL: o_prdata <= {26'h0, regulator_ctrl_reg_r};
                `OFS_SOFT_RESET0: o_prdata <= peripheral_soft_reset_regs_r[0];
                `OFS_SOFT_RESET1: o_prdata <= peripheral_soft_reset_regs_r[1];
                `OFS_SOFT_RESET2: o_prdata <= peripheral_soft_reset_regs_r[2];
                `OFS_CLOCK_GATE0: o_prdata <= clock_gate_r[0];
                `OFS_CLOCK_GATE1: o_prdata <= clock_gate_r[1];
                `OFS_CLOCK_GATE2: o_prdata <= clock_gate_r[2];
                `OFS_WDOG_LOAD: o_prdata <= watchdog_reload_value_r;
                `OFS_WDOG_VALUE: o_prdata <= wdog_count_r;
                `OFS_WDOG_CTRL: o_prdata <= {30'h0, wdog_ctrl_r};
                `OFS_WDOG_STATUS: o_prdata <= {31'h0, wdog_int_r};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Reset combining
    // ****************************************
    // Without its select bit a brown-out only raises the interrupt
    // and the core keeps running
    assign bor_reset = i_brownout & brownout_ctrl_reg_r[`BIT_BOR_RESET_SEL];
    assign o_brownout_irq = i_brownout & ~brownout_ctrl_reg_r[`BIT_BOR_RESET_SEL];
    // Level sources hold reset as long as they persist
    // Power-on stays out of sys_reset; each block ORs i_por in beside it, and the reset cause takes it first
    assign sys_reset = i_ext_reset | bor_reset | sys_req_r | wdog_reset_r;
    // Core reset decoded from the state register, free of glitches;
    // it covers the idle cycle straight after power-up
    assign o_core_reset = (seq_r == SEQ_IDLE) | (seq_r == SEQ_HOLD);

    // Regulator, reload value and clock gates survive internal resets.
    // Brown-out select is cleared by power-on only: clearing it on its own
    // reset would drop the brown-out from the tree and free the core early.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            brownout_ctrl_reg_r <= 2'b00;
            regulator_ctrl_reg_r <= '0;
            run_clock_config_r <= `RST_RUN_CLOCK_CFG;
            clock_gate_r <= '0;
            watchdog_reload_value_r <= `RST_WDOG_LOAD;
            wdog_ctrl_r <= 2'b00;
        end else if (i_por | sys_reset) begin
            if (i_por) begin
                brownout_ctrl_reg_r <= 2'b00;
            end
            run_clock_config_r <= `RST_RUN_CLOCK_CFG;
            wdog_ctrl_r <= 2'b00;
        end else if (wr) begin
            case (i_paddr)
                `OFS_BROWNOUT_CTRL: brownout_ctrl_reg_r <= i_pwdata[1:0];
                `OFS_REGULATOR_CTRL:
                    regulator_ctrl_reg_r <= i_pwdata[`POS_REGULATOR_VOLTAGE_ADJUST_W-1:0];
                `OFS_RUN_CLOCK_CFG: run_clock_config_r <= i_pwdata;
                `OFS_CLOCK_GATE0: clock_gate_r[0] <= i_pwdata;
                `OFS_CLOCK_GATE1: clock_gate_r[1] <= i_pwdata;
                `OFS_CLOCK_GATE2: clock_gate_r[2] <= i_pwdata;
                `OFS_WDOG_LOAD: watchdog_reload_value_r <= i_pwdata;
                `OFS_WDOG_CTRL: wdog_ctrl_r <= wdog_ctrl_r | i_pwdata[1:0];
                default: ;
            endcase
        end
    end

    // System reset request pulse from software
    // One-cycle pulse; the hold counter stretches it, so software
    // never has to clear the request bit
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            sys_req_r <= 1'b0;
        end else begin
            sys_req_r <= wr && i_paddr == `OFS_SYS_RESET_REQ
                && i_pwdata[`BIT_SYS_RESET_REQ];
        end
    end

    // ****************************************
    // Peripheral software resets
    // ****************************************
    // Core and test logic are not on these outputs
    // Cleared by every system reset, so no unit stays parked in reset
    // across a reboot
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            peripheral_soft_reset_regs_r <= '0;
        end else if (i_por | sys_reset) begin
            peripheral_soft_reset_regs_r <= '0;
        end else if (wr) begin
            case (i_paddr)
                `OFS_SOFT_RESET0: peripheral_soft_reset_regs_r[0] <= i_pwdata;
                `OFS_SOFT_RESET1: peripheral_soft_reset_regs_r[1] <= i_pwdata;
                `OFS_SOFT_RESET2: peripheral_soft_reset_regs_r[2] <= i_pwdata;
                default: ;
            endcase
        end
    end

    // Same bit index as clock gate; fan out to every domain of the unit
    // Core reset is folded in; the soft bits never reach the core
    always_comb begin
        for (int r = 0; r < 3; r++) begin
            for (int p = 0; p < NUM_PERIPH; p++) begin
                o_periph_reset[r][p] = {NUM_DOMAINS{peripheral_soft_reset_regs_r[r][p]
                    | o_core_reset}};
            end
        end
    end

    // ****************************************
    // Reset cause
    // ****************************************
    // Sticky; power-on wipes everything but its own bit
    // Software clears bits by writing zeros; a cause firing in the same
    // cycle is still recorded, so no reset event is lost
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            reset_cause_reg_r <= 32'h0000_0002;
        end else if (i_por) begin
            reset_cause_reg_r <= 32'h0000_0002;
        end else if (wr && i_paddr == `OFS_RESET_CAUSE) begin
            // Set wins over a simultaneous clear
            reset_cause_reg_r <= (reset_cause_reg_r & i_pwdata)
                | {27'h0, sys_req_r, wdog_reset_r, bor_reset, 1'b0, i_ext_reset};
        end else begin
            reset_cause_reg_r[`BIT_CAUSE_BOR] <= reset_cause_reg_r[`BIT_CAUSE_BOR]
                | bor_reset;
            reset_cause_reg_r[`BIT_CAUSE_EXT] <= reset_cause_reg_r[`BIT_CAUSE_EXT]
                | i_ext_reset;
            reset_cause_reg_r[`BIT_CAUSE_WDT] <= reset_cause_reg_r[`BIT_CAUSE_WDT]
                | wdog_reset_r;
            reset_cause_reg_r[`BIT_CAUSE_SW] <= reset_cause_reg_r[`BIT_CAUSE_SW]
                | sys_req_r;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    // Counter runs only once enabled; enable bits are sticky until reset
    // Limitation: enable bits are set-only, so a runaway program cannot
    // stop the watchdog; only a system or power-on reset clears them.
    // The reset output lasts one cycle; the hold counter stretches it.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wdog_count_r <= `RST_WDOG_LOAD;
            wdog_int_r <= 1'b0;
            wdog_reset_r <= 1'b0;
        end else if (i_por | (sys_reset & ~wdog_reset_r)) begin
            wdog_count_r <= watchdog_reload_value_r;
            wdog_int_r <= 1'b0;
            wdog_reset_r <= 1'b0;
        end else if (wdog_reset_r) begin
            wdog_reset_r <= 1'b0;
            wdog_int_r <= 1'b0;
            wdog_count_r <= watchdog_reload_value_r;
        end else if (wr && i_paddr == `OFS_WDOG_LOAD) begin
            wdog_count_r <= i_pwdata;
            wdog_int_r <= wdog_int_r & ~wdog_int_clr;
        end else if (wdog_ctrl_r[`BIT_WDOG_INT_EN]) begin
            if (wdog_count_r == 32'h0000_0000) begin
                wdog_count_r <= watchdog_reload_value_r;
                wdog_int_r <= 1'b1;
                wdog_reset_r <= wdog_int_r & wdog_ctrl_r[`BIT_WDOG_RESET_EN];
            end else begin
                wdog_count_r <= wdog_count_r - 32'h0000_0001;
                wdog_int_r <= wdog_int_r & ~wdog_int_clr;
            end
        end
    end
    assign o_wdog_irq = wdog_int_r;

    // ****************************************
    // Reset release and boot fetch
    // ****************************************
    // Core held while idle or holding, then one strobe each for stack
    // pointer, program counter and first instruction, then run
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SEQ_IDLE: seq_nxt = SEQ_HOLD;
            SEQ_HOLD: seq_nxt = (hold_cnt_r == 8'(HOLD_CYC - 1)) ? SEQ_SP : SEQ_HOLD;
            SEQ_SP: seq_nxt = SEQ_PC;
            SEQ_PC: seq_nxt = SEQ_INSTR;
            SEQ_INSTR: seq_nxt = SEQ_RUN;
            SEQ_RUN: seq_nxt = SEQ_RUN;
            default: seq_nxt = SEQ_IDLE;
        endcase
    end

    // Any reset cause restarts the sequence; hold stretches short pulses
    // A cause that persists keeps reloading the hold, so release only
    // starts once every source has gone quiet
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            seq_r <= SEQ_IDLE;
            hold_cnt_r <= 8'h00;
        end else if (i_por | sys_reset) begin
            seq_r <= SEQ_HOLD;
            hold_cnt_r <= 8'h00;
        end else begin
            seq_r <= seq_nxt;
            hold_cnt_r <= (seq_r == SEQ_HOLD) ? hold_cnt_r + 8'h01 : 8'h00;
        end
    end

    // Fetch strobes decoded from the state register; exactly one
    // is high per step and running stays high
    assign o_boot_fetch.fetch_sp = (seq_r == SEQ_SP);
    assign o_boot_fetch.fetch_pc = (seq_r == SEQ_PC);
    assign o_boot_fetch.fetch_instr = (seq_r == SEQ_INSTR);
    assign o_boot_fetch.running = (seq_r == SEQ_RUN);

    // ****************************************
    // Power and clock source
    // ****************************************
    // Regulator code passed through; the analog side maps each step
    assign o_regulator_voltage_adjust = regulator_ctrl_reg_r;
    assign bypass = run_clock_config_r[`POS_BYPASS];
    assign src = {1'b0, run_clock_config_r[`POS_OSC_SRC+1:`POS_OSC_SRC]};
    assign o_pll_ref_main = ~bypass & (src == 3'h0);
    // Main oscillator enabled when it is the chosen source
    assign o_main_osc_enable = (src == 3'h0);

    // Unsupported PLL setups fall back to the internal oscillator
    // Deep sleep forces the slow oscillator, but o_main_osc_enable still follows the
    // source field, so the main one stays enabled; the run setting is kept for wake-up
    // Unused source codes also fall back to the internal oscillator
    always_comb begin
        if (i_deep_sleep) begin
            o_sys_clk_sel = CLK_SLOW30K;
        end else if (!bypass) begin
            o_sys_clk_sel = o_pll_ref_main ? CLK_PLL : CLK_INTERNAL_OSC;
        end else begin
            case (src)
                3'h0: o_sys_clk_sel = CLK_MAIN;
                3'h1: o_sys_clk_sel = CLK_INTERNAL_OSC;
                3'h2: o_sys_clk_sel = CLK_INTERNAL_OSC_DV4;
                3'h3: o_sys_clk_sel = CLK_SLOW30K;
                default: o_sys_clk_sel = CLK_INTERNAL_OSC;
            endcase
        end
    end

endmodule

// ==== sim/rst_clk_chk.sv ====
`timescale 1ns/10ps
// ****************************************
// Reset and clock source checker
// ****************************************
module rst_clk_chk
    import rst_clk_pkg::*;
#(
    parameter int NUM_PERIPH = 32,
    parameter int NUM_DOMAINS = 2
) (
    // Clock, reset and bus handshake
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    // Sources and results
    input wire logic i_brownout,
    input wire logic i_deep_sleep,
    input wire logic o_core_reset,
    input wire logic [2:0][NUM_PERIPH-1:0][NUM_DOMAINS-1:0] o_periph_reset,
    input wire logic o_brownout_irq,
    input wire boot_fetch_s o_boot_fetch,
    input wire logic [2:0] o_sys_clk_sel,
    input wire logic o_pll_ref_main
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    // Fetch steps after the stack pointer, one cycle apart
    sequence fetch_tail_q;
        o_boot_fetch.fetch_pc ##1 o_boot_fetch.fetch_instr ##1 o_boot_fetch.running;
    endsequence

    // Minimum hold of the internal reset, matches HOLD_CYC of 8
    sequence hold_q;
        o_core_reset [*8];
    endsequence

    boot_order_a: assert property (o_boot_fetch.fetch_sp |=> fetch_tail_q)
        else $error("boot fetch order broken");
    boot_start_a: assert property ($fell(o_core_reset) |-> ##[0:1] o_boot_fetch.fetch_sp)
        else $error("no stack pointer fetch after release");
    hold_len_a: assert property ($rose(o_core_reset) |-> hold_q)
        else $error("internal reset too short");
    bor_reset_a: assert property (i_brownout && !o_brownout_irq |=> o_core_reset)
        else $error("brownout reset not asserted");
    bor_irq_a: assert property (o_brownout_irq |-> i_brownout)
        else $error("brownout interrupt without brownout");
    periph_all_a: assert property (o_core_reset |-> (&o_periph_reset))
        else $error("peripheral domain left out of reset");
    deep_slow_a: assert property (i_deep_sleep |-> o_sys_clk_sel == CLK_SLOW30K)
        else $error("deep sleep not on slow oscillator");
    pll_ref_a: assert property (o_pll_ref_main && !i_deep_sleep |-> o_sys_clk_sel == CLK_PLL)
        else $error("pll reference without pll select");
    sel_range_a: assert property (o_sys_clk_sel <= CLK_INTERNAL_OSC_DV4)
        else $error("clock select out of range");
    // Zero wait slave, so every access phase completes at once
    apb_ready_a: assert property (i_psel && i_penable |-> o_pready)
        else $error("access phase not answered");
endmodule

bind rst_clk_ctrl rst_clk_chk #(.NUM_PERIPH(NUM_PERIPH), .NUM_DOMAINS(NUM_DOMAINS)) u_chk (
    .i_ref_clk, .i_reset, .i_psel, .i_penable, .o_pready, .i_brownout, .i_deep_sleep,
    .o_core_reset, .o_periph_reset, .o_brownout_irq, .o_boot_fetch, .o_sys_clk_sel,
    .o_pll_ref_main
);

// ==== sim/reset_and_clock_source_control_tb_top.sv ====
`timescale 1ns/10ps
`include "rst_clk_consts.svh"
module reset_and_clock_source_control_tb_top
    import rst_clk_pkg::*;
;
    // ****************************************
    // Signals and design
    // ****************************************
    localparam logic [31:0] C_POR = 32'h0000_0001 << `BIT_CAUSE_POR;
    localparam logic [31:0] C_BOR = 32'h0000_0001 << `BIT_CAUSE_BOR;
    localparam logic [31:0] C_SW = 32'h0000_0001 << `BIT_CAUSE_SW;
    localparam logic [31:0] C_WDT = 32'h0000_0001 << `BIT_CAUSE_WDT;
    logic i_ref_clk = 1'b0, i_reset = 1'b1;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic i_por = 1'b0, i_ext_reset = 1'b0, i_brownout = 1'b0, i_deep_sleep = 1'b0;
    logic [31:0] o_prdata, rd;
    logic o_pready, o_pslverr, o_core_reset, o_brownout_irq, o_wdog_irq, err;
    logic [2:0][31:0][1:0] o_periph_reset;
    boot_fetch_s o_boot_fetch;
    logic [`POS_REGULATOR_VOLTAGE_ADJUST_W-1:0] o_regulator_voltage_adjust;
    logic o_main_osc_enable, o_pll_ref_main;
    logic [2:0] o_sys_clk_sel;
    int miscompares = 0, n_tests = 0;

    rst_clk_ctrl #(.NUM_PERIPH(32), .NUM_DOMAINS(2), .HOLD_CYC(8)) dut (
        .i_ref_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_por, .i_ext_reset, .i_brownout,
        .i_deep_sleep, .o_core_reset, .o_periph_reset, .o_brownout_irq, .o_wdog_irq,
        .o_boot_fetch, .o_regulator_voltage_adjust, .o_main_osc_enable,
        .o_sys_clk_sel, .o_pll_ref_main
    );

    // 125 MHz clock
    initial forever #4 i_ref_clk = ~i_ref_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        chk(n < 20, 1'b1);
    endtask

    // Bounded wait on the watchdog flag or the core reset
    task automatic wait_for(input logic irq, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((irq ? o_wdog_irq : o_core_reset) !== lvl && n < lim) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk(n < lim, 1'b1);
    endtask

    task automatic boot_chk(input logic [31:0] cause);
        wait_for(1'b0, 1'b0, 200);
        chk(o_boot_fetch, 4'b1000);
        @(negedge i_ref_clk);
        chk(o_boot_fetch, 4'b0100);
        @(negedge i_ref_clk);
        chk(o_boot_fetch, 4'b0010);
        @(negedge i_ref_clk);
        chk(o_boot_fetch, 4'b0001);
        apb(1'b0, `OFS_RESET_CAUSE, 32'h0000_0000);
        chk(rd, cause);
    endtask

    task automatic por_pulse();
        @(posedge i_ref_clk);
        i_por <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_por <= 1'b0;
        boot_chk(C_POR);
    endtask

    // Brownout for 13 cycles, core reset sampled on the last 12
    task automatic bor_run(input logic irq_exp, output logic r_any, output logic r_all);
        r_any = 1'b0;
        r_all = 1'b1;
        @(posedge i_ref_clk);
        i_brownout <= 1'b1;
        @(posedge i_ref_clk);
        repeat (12) begin
            @(negedge i_ref_clk);
            r_any |= o_core_reset;
            r_all &= o_core_reset;
        end
        chk(o_brownout_irq, irq_exp);
        @(posedge i_ref_clk);
        i_brownout <= 1'b0;
    endtask

    task automatic cfg(input logic b, input int s);
        apb(1'b1, `OFS_RUN_CLOCK_CFG, (32'(b) << `POS_BYPASS) | (32'(s) << `POS_OSC_SRC));
        @(negedge i_ref_clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot();
        chk(o_sys_clk_sel, CLK_INTERNAL_OSC);
        chk(o_main_osc_enable, 1'b0);
        apb(1'b0, `OFS_RUN_CLOCK_CFG, 32'h0000_0000);
        chk(rd, `RST_RUN_CLOCK_CFG);
        por_pulse();
    endtask

    task automatic t_brownout();
        logic r_any, r_all;
        bor_run(1'b1, r_any, r_all);
        chk(r_any, 1'b0);
        apb(1'b1, `OFS_BROWNOUT_CTRL, 32'h0000_0001 << `BIT_BOR_RESET_SEL);
        bor_run(1'b0, r_any, r_all);
        chk(r_all, 1'b1);
        boot_chk(C_POR | C_BOR);
    endtask

    task automatic t_periph();
        int p;
        for (int k = 0; k < 3; k++) begin
            p = 5 + 9 * k;
            apb(1'b1, `OFS_SOFT_RESET0 + 12'(4 * k), 32'h0000_0001 << p);
            @(negedge i_ref_clk);
            chk(o_periph_reset[k], 64'h0000_0000_0000_0003 << (2 * p));
            chk(o_core_reset, 1'b0);
            apb(1'b1, `OFS_SOFT_RESET0 + 12'(4 * k), 32'h0000_0000);
            @(negedge i_ref_clk);
            chk(o_periph_reset[k], 64'h0000_0000_0000_0000);
        end
    endtask

    task automatic t_sysreq();
        apb(1'b1, `OFS_SYS_RESET_REQ, 32'h0000_0001 << `BIT_SYS_RESET_REQ);
        wait_for(1'b0, 1'b1, 10);
        boot_chk(C_POR | C_BOR | C_SW);
    endtask

    task automatic t_clock();
        clk_sel_e m [4] = '{CLK_MAIN, CLK_INTERNAL_OSC, CLK_INTERNAL_OSC_DV4, CLK_SLOW30K};
        for (int s = 0; s < 4; s++) begin
            cfg(1'b1, s);
            chk(o_sys_clk_sel, m[s]);
            chk(o_pll_ref_main, 1'b0);
        end
        cfg(1'b1, 0);
        repeat (16) @(negedge i_ref_clk);
        chk(o_main_osc_enable, 1'b1);
        cfg(1'b0, 0);
        chk({o_pll_ref_main, o_sys_clk_sel}, {1'b1, CLK_PLL});
        cfg(1'b0, 1);
        chk({o_pll_ref_main, o_sys_clk_sel}, {1'b0, CLK_INTERNAL_OSC});
        @(posedge i_ref_clk);
        i_deep_sleep <= 1'b1;
        @(negedge i_ref_clk);
        chk(o_sys_clk_sel, CLK_SLOW30K);
        @(posedge i_ref_clk);
        i_deep_sleep <= 1'b0;
    endtask

    task automatic t_reg();
        apb(1'b1, `OFS_REGULATOR_CTRL, 32'h0000_002A);
        apb(1'b0, `OFS_REGULATOR_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_002A);
        chk(o_regulator_voltage_adjust, 6'h2A);
        apb(1'b1, 12'h3F0, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h3F0, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
    endtask

    task automatic t_wdog();
        logic hit;
        hit = 1'b0;
        apb(1'b1, `OFS_WDOG_LOAD, 32'h0000_0014);
        apb(1'b1, `OFS_WDOG_CTRL, 32'h0000_0001 << `BIT_WDOG_INT_EN);
        wait_for(1'b1, 1'b1, 100);
        apb(1'b0, `OFS_WDOG_VALUE, 32'h0000_0000);
        chk(rd <= 32'h0000_0014, 1'b1);
        repeat (60) begin
            @(negedge i_ref_clk);
            hit |= o_core_reset;
        end
        chk(hit, 1'b0);
        apb(1'b1, `OFS_WDOG_INT_CLR, 32'h0000_0000);
        apb(1'b1, `OFS_WDOG_CTRL, 32'h0000_0003);
        wait_for(1'b1, 1'b1, 100);
        wait_for(1'b0, 1'b1, 100);
        boot_chk(C_POR | C_BOR | C_SW | C_WDT);
    endtask

    // ****************************************
    // Sequence, watchdog and verdict
    // ****************************************
    task automatic results();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_boot();
        t_brownout();
        t_periph();
        t_sysreq();
        t_clock();
        t_reg();
        t_wdog();
        por_pulse();
        results();
    end

    // Whole run needs a few thousand cycles at most
    initial begin
        #160000;
        miscompares++;
        results();
    end
endmodule
